// ==== core/mpsc_top.sv ====
/*
 * power mode sequencer, strap decoder, status colour and DTR/DSR control.
 * assumes all pins except presetn are synchronous to pclk and an APB master on the register side.
 */
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
module mpsc_top #(
    parameter int HOLD_CYC = mpsc_pkg::FACTORY_HOLD_CYC, // ten second strap hold
    parameter int BLINK_CYC = mpsc_pkg::BLINK_CYC // half period of traffic blink
) (
    input wire logic pclk, // 10 MHz clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // unmapped address
    input wire logic reset_pin_n, // external reset pin, pulled high
    input wire logic switch_1_n, // option switch one
    input wire logic switch_2_n, // option switch two
    input wire logic dsr, // host control line
    input wire logic [mpsc_pkg::GPIO_W-1:0] gpio_in, // gpio input levels
    input wire logic rtc_wake, // real time counter event
    input wire logic radio_wake, // radio event
    input wire logic nfc_field, // field detected
    input wire logic comp_event, // comparator/low power comparator
    input wire logic data_activity, // traffic pulse
    input wire logic peer_conn, // serial service peer connected
    input wire logic bonded_conn, // bonded device connected
    input wire logic link_conn, // link layer connection up
    input wire logic nv_save_done, // store finished
    output logic nv_save_req, // store parameters request
    output logic soft_reset, // reboot pulse
    output logic slow_clk_en, // 32.768 kHz tick in standby
    output logic core_halt, // all functions stopped
    output logic ram_retain_only, // only retained ram powered
    output logic uart_default, // uart settings to default pulse
    output logic boot_mode, // bootloader active
    output logic factory_reset, // factory defaults pulse
    output logic cmd_mode_req, // enter command mode pulse
    output logic disconnect_req, // disconnect/connectable pulse
    output logic uart_en, // rest of uart enabled
    output logic red_n, // red status, low lights
    output logic green_n, // green status, low lights
    output logic blue_n, // blue status, low lights
    output logic dtr, // status indication
    output logic irq // level interrupt
);
    // ****************************************
    // declarations
    // ****************************************
    mpsc_pkg::mpsc_state_type state;
    mpsc_pkg::mpsc_state_type next_state;
    logic [12:0] ctrl;
    logic [4:0] wake_en;
    logic [mpsc_pkg::IRQ_W-1:0] irq_stat;
    logic [mpsc_pkg::IRQ_W-1:0] irq_mask;
    logic [mpsc_pkg::IRQ_W-1:0] irq_set;
    logic [mpsc_pkg::GPIO_W-1:0] latch;
    logic [mpsc_pkg::GPIO_W-1:0] gpio_prev;
    logic [1:0] cmd_pend;
    logic save_to_reboot;
    logic dsr_prev;
    logic [31:0] hold_cnt;
    logic [31:0] blink_cnt;
    logic blink_off;
    logic [15:0] slow_cnt;
    logic wr_acc;
    logic rd_set;
    logic [31:0] next_rdata;
    logic map_hit;
    logic dsr_edge;
    logic gsel_edge;
    logic gpio_change;
    logic ext_wake;
    logic int_wake;
    logic [1:0] link;
    logic [4:0] gsel;
    assign link = ctrl[mpsc_pkg::CTRL_LINK_LSB +: 2];
    assign gsel = ctrl[mpsc_pkg::CTRL_GSEL_LSB +: 5];
    assign wr_acc = psel && penable && pwrite;
    assign rd_set = psel && !penable && !pwrite;
    // events that raise the sticky interrupt bits, msb first
    assign irq_set = {dsr_edge && state == mpsc_pkg::ST_ACTIVE, factory_reset,
        state == mpsc_pkg::ST_REBOOT, state == mpsc_pkg::ST_SAVE && nv_save_done,
        state == mpsc_pkg::ST_STANDBY && next_state == mpsc_pkg::ST_ACTIVE};
    // ****************************************
    // apb slave
    // ****************************************
    // read mux and decode, evaluated in the setup cycle
    always_comb
    begin
        map_hit = 1'b1;
        next_rdata = 32'h0000_0000;
        unique case (paddr)
            mpsc_pkg::ADDR_CTRL: next_rdata[12:0] = ctrl;
            mpsc_pkg::ADDR_CMD: next_rdata[1:0] = cmd_pend;
            mpsc_pkg::ADDR_STATUS: next_rdata[9:0] = {boot_mode, uart_en, core_halt,
                slow_clk_en, state};
            mpsc_pkg::ADDR_IRQ_STAT: next_rdata[mpsc_pkg::IRQ_W-1:0] = irq_stat;
            mpsc_pkg::ADDR_IRQ_MASK: next_rdata[mpsc_pkg::IRQ_W-1:0] = irq_mask;
            mpsc_pkg::ADDR_WAKE_EN: next_rdata[4:0] = wake_en;
            mpsc_pkg::ADDR_LATCH: next_rdata[mpsc_pkg::GPIO_W-1:0] = latch;
            default: map_hit = 1'b0;
        endcase
    end

    // registered answer, ready stays high so every access ends in its first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            if (psel && !penable)
            begin
                prdata <= rd_set ? next_rdata : 32'h0000_0000;
                pslverr <= !map_hit;
            end
        end
    end

    // software control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= mpsc_pkg::CTRL_RESET;
            wake_en <= mpsc_pkg::WAKE_EN_RESET;
            irq_mask <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr == mpsc_pkg::ADDR_CTRL)
                ctrl <= pwdata[12:0];
            if (paddr == mpsc_pkg::ADDR_WAKE_EN)
                wake_en <= pwdata[4:0];
            if (paddr == mpsc_pkg::ADDR_IRQ_MASK)
                irq_mask <= pwdata[mpsc_pkg::IRQ_W-1:0];
        end
    end

    // command pending bits, cleared one cycle after being set whether the sequencer takes them or not
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmd_pend <= 2'h0;
        else if (!reset_pin_n || state != mpsc_pkg::ST_ACTIVE)
            cmd_pend <= 2'h0;
        else if (cmd_pend != 2'h0)
            cmd_pend <= 2'h0;
        else if (wr_acc && paddr == mpsc_pkg::ADDR_CMD)
            cmd_pend <= pwdata[1:0];
    end

    // ****************************************
    // interrupts
    // ****************************************
    // sticky status, a read clears it but a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat <= '0;
        else if (psel && penable && !pwrite && paddr == mpsc_pkg::ADDR_IRQ_STAT)
            irq_stat <= irq_set;
        else
            irq_stat <= irq_stat | irq_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat & irq_mask);
    end

    // ****************************************
    // event detection
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dsr_prev <= 1'b1;
            gpio_prev <= '0;
        end
        else
        begin
            dsr_prev <= dsr;
            gpio_prev <= gpio_in;
        end
    end

    assign dsr_edge = dsr != dsr_prev;
    assign gsel_edge = ctrl[mpsc_pkg::CTRL_GSEL_EN] && gsel < 5'(mpsc_pkg::GPIO_W)
        && gpio_in[gsel] != gpio_prev[gsel]; // R12
    assign gpio_change = ctrl[mpsc_pkg::CTRL_LATCH_EN] && gpio_in != latch; // R11
    // only outside causes leave sleep
    assign ext_wake = gpio_change || gsel_edge || (wake_en[mpsc_pkg::WK_NFC] && nfc_field)
        || (wake_en[mpsc_pkg::WK_COMP] && comp_event)
        || (wake_en[mpsc_pkg::WK_GPIO] && gpio_in != gpio_prev); // R9
    assign int_wake = (wake_en[mpsc_pkg::WK_RTC] && rtc_wake)
        || (wake_en[mpsc_pkg::WK_RADIO] && radio_wake) || ext_wake; // R7

    // gpio levels caught on the way into sleep
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            latch <= '0;
        else if (next_state == mpsc_pkg::ST_SLEEP && state != mpsc_pkg::ST_SLEEP)
            latch <= gpio_in; // R11
    end

    // ****************************************
    // power sequencer
    // ****************************************
    always_comb
    begin
        next_state = state;
        unique case (state)
            mpsc_pkg::ST_START: next_state = mpsc_pkg::ST_ACTIVE;
            mpsc_pkg::ST_ACTIVE:
            begin
                if (cmd_pend[mpsc_pkg::CMD_POWER_OFF])
                    next_state = mpsc_pkg::ST_SAVE; // R5
                else if (dsr_edge && ctrl[mpsc_pkg::CTRL_DSR_LSB +: 2] == mpsc_pkg::DSR_SLEEP)
                    next_state = mpsc_pkg::ST_SAVE; // R18
                else if (gsel_edge)
                    next_state = mpsc_pkg::ST_SLEEP; // R12
                else if (cmd_pend[mpsc_pkg::CMD_STANDBY])
                    next_state = mpsc_pkg::ST_STANDBY;
            end
            mpsc_pkg::ST_SAVE:
            begin
                if (nv_save_done)
                    next_state = save_to_reboot ? mpsc_pkg::ST_REBOOT : mpsc_pkg::ST_SLEEP;
            end
            mpsc_pkg::ST_STANDBY:
            begin
                if (int_wake)
                    next_state = mpsc_pkg::ST_ACTIVE; // R7
            end
            mpsc_pkg::ST_SLEEP:
            begin
                if (ext_wake || (dsr_edge
                    && ctrl[mpsc_pkg::CTRL_DSR_LSB +: 2] == mpsc_pkg::DSR_SLEEP))
                    next_state = mpsc_pkg::ST_REBOOT; // R10
            end
            mpsc_pkg::ST_REBOOT: next_state = mpsc_pkg::ST_START;
            default: next_state = mpsc_pkg::ST_START;
        endcase
    end

    // the reset pin drops straight back to start, skipping any store
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= mpsc_pkg::ST_START;
        else if (!reset_pin_n)
            state <= mpsc_pkg::ST_START; // R4
        else
            state <= next_state;
    end

    // remembers whether the store ends in a reboot or in sleep
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            save_to_reboot <= 1'b0;
        else if (state == mpsc_pkg::ST_ACTIVE && next_state == mpsc_pkg::ST_SAVE)
            save_to_reboot <= cmd_pend[mpsc_pkg::CMD_POWER_OFF]; // R5
    end

    // sequencer outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nv_save_req <= 1'b0;
            soft_reset <= 1'b0;
            core_halt <= 1'b0;
            ram_retain_only <= 1'b0;
        end
        else
        begin
            nv_save_req <= reset_pin_n && next_state == mpsc_pkg::ST_SAVE; // R4
            soft_reset <= reset_pin_n && next_state == mpsc_pkg::ST_REBOOT; // R10
            core_halt <= reset_pin_n && next_state == mpsc_pkg::ST_SLEEP; // R8
            ram_retain_only <= reset_pin_n && next_state == mpsc_pkg::ST_SLEEP; // R8
        end
    end

    // slow tick from a divider, running only in standby
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slow_cnt <= 16'h0000;
            slow_clk_en <= 1'b0;
        end
        else if (state != mpsc_pkg::ST_STANDBY)
        begin
            slow_cnt <= 16'h0000;
            slow_clk_en <= 1'b0;
        end
        else
        begin
            slow_clk_en <= slow_cnt == 16'(mpsc_pkg::SLOW_DIV - 1); // R6
            slow_cnt <= (slow_cnt == 16'(mpsc_pkg::SLOW_DIV - 1)) ? 16'h0000 : slow_cnt + 16'h0001;
        end
    end

    // ****************************************
    // start-up straps
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            uart_default <= 1'b0;
            boot_mode <= 1'b0;
            factory_reset <= 1'b0;
            hold_cnt <= 32'h0000_0000;
        end
        else
        begin
            uart_default <= 1'b0;
            factory_reset <= 1'b0;
            if (!reset_pin_n)
            begin
                boot_mode <= 1'b0;
                hold_cnt <= 32'h0000_0000;
            end
            else if (state == mpsc_pkg::ST_START)
            begin
                uart_default <= !switch_2_n; // R13
                boot_mode <= !switch_1_n && !switch_2_n; // R14
                hold_cnt <= 32'h0000_0001;
            end
            else if (hold_cnt != 32'h0000_0000)
            begin
                if (switch_1_n || switch_2_n)
                    hold_cnt <= 32'h0000_0000;
                else if (hold_cnt == 32'(HOLD_CYC))
                begin
                    factory_reset <= 1'b1; // R15
                    boot_mode <= 1'b0; // R15
                    hold_cnt <= 32'h0000_0000;
                end
                else
                    hold_cnt <= hold_cnt + 32'h0000_0001;
            end
        end
    end

    // ****************************************
    // host control lines
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_mode_req <= 1'b0;
            disconnect_req <= 1'b0;
            uart_en <= 1'b1;
        end
        else
        begin
            cmd_mode_req <= state == mpsc_pkg::ST_ACTIVE && dsr_edge
                && ctrl[mpsc_pkg::CTRL_DSR_LSB +: 2] == mpsc_pkg::DSR_CMD_MODE; // R16
            disconnect_req <= state == mpsc_pkg::ST_ACTIVE && dsr_edge
                && ctrl[mpsc_pkg::CTRL_DSR_LSB +: 2] == mpsc_pkg::DSR_DISCONNECT; // R16
            if (ctrl[mpsc_pkg::CTRL_DSR_LSB +: 2] == mpsc_pkg::DSR_UART_EN)
                uart_en <= !dsr; // R16
            else
                uart_en <= 1'b1;
        end
    end

    // dtr source select
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dtr <= 1'b0;
        else
        begin
            unique case (ctrl[mpsc_pkg::CTRL_DTR_LSB +: 2])
                mpsc_pkg::DTR_MODE: dtr <= link == mpsc_pkg::LINK_CMD_IDLE; // R17
                mpsc_pkg::DTR_PEER: dtr <= peer_conn; // R17
                mpsc_pkg::DTR_BONDED: dtr <= bonded_conn; // R17
                mpsc_pkg::DTR_LINK: dtr <= link_conn; // R17
            endcase
        end
    end

    // ****************************************
    // status colours
    // ****************************************
    // traffic starts a dark gap in the connected colour once the previous blink is over
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blink_cnt <= 32'h0000_0000;
            blink_off <= 1'b0;
        end
        else if (link != mpsc_pkg::LINK_CONNECTED)
        begin
            blink_cnt <= 32'h0000_0000;
            blink_off <= 1'b0;
        end
        else if (blink_cnt != 32'h0000_0000)
        begin
            blink_cnt <= blink_cnt - 32'h0000_0001;
            if (blink_cnt == 32'(BLINK_CYC))
                blink_off <= 1'b0; // R3
        end
        else if (data_activity)
        begin
            blink_cnt <= 32'(2 * BLINK_CYC);
            blink_off <= 1'b1; // R3
        end
    end

    // colours dark until start-up done and while asleep
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            red_n <= 1'b1; // R19
            green_n <= 1'b1; // R19
            blue_n <= 1'b1; // R19
        end
        else if (!reset_pin_n || state == mpsc_pkg::ST_START || state == mpsc_pkg::ST_REBOOT
            || state == mpsc_pkg::ST_SLEEP)
        begin
            red_n <= 1'b1; // R19
            green_n <= 1'b1;
            blue_n <= 1'b1;
        end
        else
        begin
            unique case (link)
                mpsc_pkg::LINK_DATA_IDLE: {red_n, green_n, blue_n} <= 3'h5; // R1 R2
                mpsc_pkg::LINK_CMD_IDLE: {red_n, green_n, blue_n} <= 3'h1; // R1 R2
                mpsc_pkg::LINK_CONNECTING: {red_n, green_n, blue_n} <= 3'h2; // R1 R2
                mpsc_pkg::LINK_CONNECTED: {red_n, green_n, blue_n} <= {2'h3, blink_off}; // R1 R3
            endcase
        end
    end
endmodule

// ==== core/mpsc_pkg.sv ====
/*
 * constants, register map and state codes of the module power/status controller.
 * assumes a 10 MHz pclk and an APB master with 32-bit data.
 */
// Function
// R1: colour code per link state on three outputs
// R2: colour outputs are active low
// R3: connected colour blinks on data traffic
// R4: reset pin low: hard reset, nothing saved
// R5: power-off command saves, then software reset
// R6: standby keeps state, runs 32.768 kHz tick
// R7: standby wakes on internal or sensor events
// R8: sleep halts all, keeps retained RAM only
// R9: sleep wakes only on external events
// R10: every sleep exit ends in full reboot
// R11: latch GPIO on sleep entry, wake on change
// R12: any GPIO selectable as sleep control
// R13: switch two low at start: UART defaults
// R14: both switches low at start: bootloader
// R15: both low ten seconds: factory defaults
// R16: DSR line controls mode, link, UART, sleep
// R17: DTR shows selected mode or connection status
// R18: DSR power toggle saves settings first
// R19: all colours dark until mode known
package mpsc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_WAKE_EN = 8'h14;
    localparam logic [7:0] ADDR_LATCH = 8'h18;
    localparam int GPIO_W = 19;
    localparam int IRQ_W = 5;
    // ctrl fields
    localparam int CTRL_LINK_LSB = 0;  // 2 bits: link state
    localparam int CTRL_DTR_LSB = 2;   // 2 bits: dtr source
    localparam int CTRL_DSR_LSB = 4;   // 2 bits: dsr function
    localparam int CTRL_LATCH_EN = 6;
    localparam int CTRL_GSEL_EN = 7;
    localparam int CTRL_GSEL_LSB = 8;  // 5 bits: sleep control gpio
    localparam logic [12:0] CTRL_RESET = 13'h0000;
    // cmd bits
    localparam int CMD_POWER_OFF = 0;
    localparam int CMD_STANDBY = 1;
    // wake enable bits
    localparam int WK_RTC = 0;
    localparam int WK_RADIO = 1;
    localparam int WK_NFC = 2;
    localparam int WK_COMP = 3;
    localparam int WK_GPIO = 4;
    localparam logic [4:0] WAKE_EN_RESET = 5'h1f;
    // irq bits
    localparam int IRQ_STANDBY_WAKE = 0;
    localparam int IRQ_SAVE_DONE = 1;
    localparam int IRQ_REBOOT = 2;
    localparam int IRQ_FACTORY = 3;
    localparam int IRQ_DSR = 4;
    // ****************************************
    // codes
    // ****************************************
    localparam logic [1:0] LINK_DATA_IDLE = 2'h0;
    localparam logic [1:0] LINK_CMD_IDLE = 2'h1;
    localparam logic [1:0] LINK_CONNECTING = 2'h2;
    localparam logic [1:0] LINK_CONNECTED = 2'h3;
    localparam logic [1:0] DTR_MODE = 2'h0;
    localparam logic [1:0] DTR_PEER = 2'h1;
    localparam logic [1:0] DTR_BONDED = 2'h2;
    localparam logic [1:0] DTR_LINK = 2'h3;
    localparam logic [1:0] DSR_CMD_MODE = 2'h0;
    localparam logic [1:0] DSR_DISCONNECT = 2'h1;
    localparam logic [1:0] DSR_UART_EN = 2'h2;
    localparam logic [1:0] DSR_SLEEP = 2'h3;
    typedef enum logic [5:0] {
        ST_START = 6'h01,
        ST_ACTIVE = 6'h02,
        ST_SAVE = 6'h04,
        ST_STANDBY = 6'h08,
        ST_SLEEP = 6'h10,
        ST_REBOOT = 6'h20
    } mpsc_state_type;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 10000000;
    localparam int SLOW_HZ = 32768;
    localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
    localparam int FACTORY_HOLD_S = 10;
    localparam int FACTORY_HOLD_CYC = FACTORY_HOLD_S * CLK_HZ;
    localparam int BLINK_MS = 50;
    localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
endpackage

// ==== verif/mpsc_properties.sv ====
/* port checker for mpsc_top.
   assumes the design's pclk and presetn. */
`timescale 1ns/100ps
module mpsc_properties (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic reset_pin_n, // reset pin
    input wire logic nv_save_req, // store request
    input wire logic nv_save_done, // store done
    input wire logic soft_reset, // reboot pulse
    input wire logic core_halt, // sleep halt
    input wire logic ram_retain_only, // retention
    input wire logic slow_clk_en, // standby tick
    input wire logic uart_default, // uart default pulse
    input wire logic red_n, // red
    input wire logic green_n, // green
    input wire logic blue_n // blue
);
    // ****
    // properties
    // ****
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_pin_low; !reset_pin_n [*2]; endsequence
    sequence s_saved; nv_save_req && nv_save_done; endsequence
    a_pin_dark: assert property (s_pin_low |-> red_n && green_n && blue_n)
        else $error("colour lit in reset");
    a_pin_nosave: assert property (s_pin_low |-> !nv_save_req)
        else $error("store in hard reset");
    a_halt_dark: assert property (core_halt [*2] |-> red_n && green_n && blue_n)
        else $error("colour lit in sleep");
    a_halt_ram: assert property (core_halt |-> ram_retain_only)
        else $error("retention missing");
    a_save_ends: assert property (s_saved |-> ##[1:2] (soft_reset || core_halt))
        else $error("no end after store");
    a_reboot_pulse: assert property (soft_reset |=> !soft_reset)
        else $error("reboot pulse long");
    a_wake_reboot: assert property ($fell(core_halt) && reset_pin_n && $past(reset_pin_n)
        |-> ##[0:1] soft_reset)
        else $error("sleep exit without reboot");
    a_tick_standby: assert property (slow_clk_en |-> !core_halt && !nv_save_req)
        else $error("tick outside standby");
    a_colour_code: assert property ({red_n, green_n, blue_n} inside
        {3'h5, 3'h1, 3'h2, 3'h6, 3'h7})
        else $error("bad colour code");
    a_uart_pulse: assert property (uart_default |=> !uart_default)
        else $error("uart default long");
endmodule

// ==== verif/mpsc_host_model.sv ====
/* host on the control lines and straps.
   assumes requests from the bench at pclk edges. */
`timescale 1ns/100ps
module mpsc_host_model (
    input wire logic pclk, // clock
    input wire logic flip, // change dsr once
    input wire logic boot_req, // pull straps low
    output logic dsr, // control line
    output logic switch_1_n, // option switch one
    output logic switch_2_n // option switch two
);
    // straps low while boot requested
    assign switch_1_n = !boot_req;
    assign switch_2_n = !boot_req;
    // dsr changes once per request
    initial dsr = 1'b1;
    always @(posedge pclk) if (flip) dsr <= !dsr;
endmodule

// ==== verif/module_power_status_control_bench.sv ====
/* bench of mpsc_top with host model.
   assumes a 10 MHz pclk and short hold counts. */
`timescale 1ns/100ps
module module_power_status_control_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, reset_pin_n, dsr;
    logic switch_1_n, switch_2_n, rtc_wake, radio_wake, nfc_field, comp_event;
    logic data_activity, peer_conn, bonded_conn, link_conn, nv_save_done, nv_save_req;
    logic soft_reset, slow_clk_en, core_halt, ram_retain_only, uart_default, boot_mode;
    logic factory_reset, cmd_mode_req, disconnect_req, uart_en, red_n, green_n, blue_n;
    logic dtr, irq, flip, boot_req, err, seen_ud;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [mpsc_pkg::GPIO_W-1:0] gpio_in;
    int mismatches, n_compared, cyc;
    mpsc_top #(.HOLD_CYC(50), .BLINK_CYC(4)) DUT (.*);
    mpsc_host_model host (.pclk, .flip, .boot_req, .dsr, .switch_1_n, .switch_2_n);
    // clock and watchdog
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = !pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (uart_default) seen_ud <= 1'b1;
        if (cyc == 5000)
        begin
            mismatches++;
            report_and_stop;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("Error %0t got %h exp %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task pause;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    task chk_awake;
        pause;
        apb(1'b0, 8'h08, 32'h0);
        chk(q & 32'h3f, 32'h2);
    endtask
    task ack_save;
        @(posedge pclk iff nv_save_req);
        nv_save_done <= 1'b1;
        @(posedge pclk);
        nv_save_done <= 1'b0;
    endtask
    task t_straps;
        pause;
        chk(32'(boot_mode), 32'h1);
        @(posedge pclk iff factory_reset);
        boot_req <= 1'b0;
        @(negedge pclk);
        chk(32'(boot_mode), 32'h0);
        chk(32'(seen_ud), 32'h1);
    endtask
    task t_regs;
        apb(1'b0, 8'h14, 32'h0);
        chk(q, 32'h1f);
        apb(1'b0, 8'h1c, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, 8'h10, 32'h1f);
        pause;
        chk(32'(irq), 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        chk(q, 32'h8);
        pause;
        chk(32'(irq), 32'h0);
    endtask
    task t_leds;
        logic [2:0] exp [4] = '{3'h5, 3'h1, 3'h2, 3'h6};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 8'h00, 32'(i));
            pause;
            chk(32'({red_n, green_n, blue_n}), 32'(exp[i]));
        end
        @(posedge pclk);
        data_activity <= 1'b1;
        @(posedge pclk);
        data_activity <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(32'(blue_n), 32'h1);
    endtask
    task t_pin;
        @(posedge pclk);
        reset_pin_n <= 1'b0;
        pause;
        chk(32'({red_n, green_n, blue_n, nv_save_req}), 32'he);
        @(posedge pclk);
        reset_pin_n <= 1'b1;
        pause;
    endtask
    task t_power_off;
        apb(1'b1, 8'h04, 32'h1);
        ack_save;
        @(posedge pclk iff soft_reset);
        chk_awake;
    endtask
    task t_standby;
        apb(1'b1, 8'h04, 32'h2);
        @(posedge pclk iff slow_clk_en);
        chk(32'(core_halt), 32'h0);
        rtc_wake <= 1'b1;
        @(posedge pclk);
        rtc_wake <= 1'b0;
        chk_awake;
    endtask
    task t_sleep;
        apb(1'b1, 8'h00, 32'h30);
        flip <= 1'b1;
        @(posedge pclk);
        flip <= 1'b0;
        ack_save;
        @(posedge pclk iff core_halt);
        @(negedge pclk);
        chk(32'(ram_retain_only), 32'h1);
        @(posedge pclk);
        nfc_field <= 1'b1;
        @(posedge pclk iff soft_reset);
        nfc_field <= 1'b0;
        chk_awake;
    endtask
    task t_dsr;
        apb(1'b1, 8'h00, 32'h25);
        {peer_conn, flip} <= 2'b11;
        @(posedge pclk);
        flip <= 1'b0;
        pause;
        chk(32'({dtr, uart_en}), 32'h2);
    endtask
    task report_and_stop;
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, gpio_in, flip, seen_ud} = '0;
        {rtc_wake, radio_wake, nfc_field, comp_event, data_activity} = '0;
        {peer_conn, bonded_conn, link_conn, nv_save_done} = '0;
        {reset_pin_n, boot_req} = 2'b11;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_straps;
        t_regs;
        t_leds;
        t_pin;
        t_power_off;
        t_standby;
        t_sleep;
        t_dsr;
        report_and_stop;
    end
endmodule
bind mpsc_top mpsc_properties chk_ports (.pclk, .presetn, .reset_pin_n, .nv_save_req,
    .nv_save_done, .soft_reset, .core_halt, .ram_retain_only, .slow_clk_en, .uart_default,
    .red_n, .green_n, .blue_n);
